// [verilog/mpc_defs.vh]
// register map, field positions and reset values of the pwm counter
// included by the pwm counter design file; definitions only
`ifndef MPC_DEFS_VH
`define MPC_DEFS_VH

// register offsets (index on the 8-bit register port)
`define MPC_OFF_CONTROL 4'h0
`define MPC_OFF_DUTY0_LOW 4'h1
`define MPC_OFF_DUTY0_HIGH 4'h2
`define MPC_OFF_DUTY1_LOW 4'h3
`define MPC_OFF_DUTY1_HIGH 4'h4
`define MPC_OFF_DUTY2_LOW 4'h5
`define MPC_OFF_DUTY2_HIGH 4'h6
`define MPC_OFF_PERIOD_LOW 4'h7
`define MPC_OFF_PERIOD_HIGH 4'h8
`define MPC_OFF_COUNT_LOW 4'h9
`define MPC_OFF_COUNT_HIGH 4'ha
`define MPC_OFF_IRQ_STATUS 4'hb
`define MPC_OFF_IRQ_MASK 4'hc

// control register fields
`define MPC_CTL_RELOAD 0
`define MPC_CTL_IRQSEL_LO 1
`define MPC_CTL_IRQSEL_HI 2
`define MPC_CTL_RUN 3
`define MPC_CTL_DIV_LO 4
`define MPC_CTL_DIV_HI 5
`define MPC_CTL_ALIGN_LO 6
`define MPC_CTL_ALIGN_HI 7

// interrupt status bits
`define MPC_IRQ_UNDERFLOW 0
`define MPC_IRQ_DUTY_UP 1
`define MPC_IRQ_DUTY_DOWN 2
`define MPC_IRQ_BITS 3

// reset values
`define MPC_RST_BYTE 8'h00
`define MPC_RST_WORD 10'h000

`endif

// [verilog/mpc_prescaler.v]
// pwm clock prescaler: one-cycle tick at source rate divided by 1, 2, 4 or 8
// assumes i_run low holds the divider at zero so a restart is aligned
`timescale 1ns/100ps

module mpc_prescaler (
  input wire i_mclk, // source clock
  input wire i_reset, // synchronous reset, high
  input wire i_run, // counting enabled
  input wire [1:0] i_div, // division code
  output reg o_tick // one-cycle counter enable
);

reg [2:0] div_cnt_reg;
reg [2:0] div_cnt_next;
wire [2:0] div_last;

assign div_last = (3'h1 << i_div) - 3'h1;

always @* begin
  div_cnt_next = div_cnt_reg + 3'h1;
  if (div_cnt_reg >= div_last) begin
    div_cnt_next = 3'h0;
  end
end

always @(posedge i_mclk) begin
  if (i_reset || !i_run) begin
    div_cnt_reg <= 3'h0;
    o_tick <= 1'b0;
  end else begin
    div_cnt_reg <= div_cnt_next;
    o_tick <= (div_cnt_reg >= div_last);
  end
end

endmodule

// [verilog/mpc_pwm_counter.v]
// 10-bit three-channel motor pwm counter with register port and interrupt
// assumes a register master on i_mclk; i_mclk is the pwm source clock
`timescale 1ns/100ps
`include "mpc_defs.vh"

module mpc_pwm_counter (
  input wire i_mclk, // pwm source clock, 40 MHz
  input wire i_reset, // synchronous reset, high
  input wire [3:0] i_addr, // register offset
  input wire [7:0] i_wdata, // write data
  input wire i_wr, // write strobe
  input wire i_rd, // read strobe
  output reg [7:0] o_rdata, // read data, cycle after i_rd
  output reg [2:0] o_modulated_output, // channel pwm outputs
  output reg o_irq // level interrupt
);

localparam ALIGN_EDGE = 2'h0;
localparam ALIGN_CENTRE1 = 2'h2;
localparam ALIGN_CENTRE2 = 2'h3;

////////////////////////////////////////////////////////////////
// registers

reg [7:0] control_reg;
reg [9:0] period_value_reg;
reg [9:0] duty_value_ch0_reg;
reg [9:0] duty_value_ch1_reg;
reg [9:0] duty_value_ch2_reg;
reg [9:0] act_period_reg;
reg [9:0] act_duty0_reg;
reg [9:0] act_duty1_reg;
reg [9:0] act_duty2_reg;
reg [9:0] count_reg;
reg down_reg;
reg [2:0] irq_status_reg;
reg [2:0] irq_mask_reg;
reg reload_clr_reg;

wire counter_run;
wire [1:0] counter_clock_div;
wire [1:0] align_mode_sel;
wire [1:0] centre_duty_irq_sel;
wire reload_request;
wire centre;
wire tick;
wire wr_ctl;
wire rd_status;
wire underflow;
wire load_now;
wire duty_hit;
wire [2:0] irq_set;
reg [9:0] count_next;
reg down_next;

assign counter_run = control_reg[`MPC_CTL_RUN];
assign counter_clock_div = control_reg[`MPC_CTL_DIV_HI:`MPC_CTL_DIV_LO];
assign align_mode_sel = control_reg[`MPC_CTL_ALIGN_HI:`MPC_CTL_ALIGN_LO];
assign centre_duty_irq_sel = control_reg[`MPC_CTL_IRQSEL_HI:`MPC_CTL_IRQSEL_LO];
assign reload_request = control_reg[`MPC_CTL_RELOAD];
assign centre = align_mode_sel[1];
assign wr_ctl = i_wr && (i_addr == `MPC_OFF_CONTROL);
assign rd_status = i_rd && (i_addr == `MPC_OFF_IRQ_STATUS);

////////////////////////////////////////////////////////////////
// prescaler

mpc_prescaler u_prescaler (
  .i_mclk(i_mclk),
  .i_reset(i_reset),
  .i_run(counter_run),
  .i_div(counter_clock_div),
  .o_tick(tick)
);

////////////////////////////////////////////////////////////////
// register writes

always @(posedge i_mclk) begin
  if (i_reset) begin
    control_reg <= `MPC_RST_BYTE;
    period_value_reg <= `MPC_RST_WORD;
    duty_value_ch0_reg <= `MPC_RST_WORD;
    duty_value_ch1_reg <= `MPC_RST_WORD;
    duty_value_ch2_reg <= `MPC_RST_WORD;
    irq_mask_reg <= 3'h0;
  end else begin
    if (wr_ctl) begin
      control_reg <= i_wdata;
    end else if (reload_clr_reg) begin
      control_reg[`MPC_CTL_RELOAD] <= 1'b0;
    end
    if (i_wr) begin
      case (i_addr)
        `MPC_OFF_DUTY0_LOW: duty_value_ch0_reg[7:0] <= i_wdata;
        `MPC_OFF_DUTY0_HIGH: duty_value_ch0_reg[9:8] <= i_wdata[1:0];
        `MPC_OFF_DUTY1_LOW: duty_value_ch1_reg[7:0] <= i_wdata;
        `MPC_OFF_DUTY1_HIGH: duty_value_ch1_reg[9:8] <= i_wdata[1:0];
        `MPC_OFF_DUTY2_LOW: duty_value_ch2_reg[7:0] <= i_wdata;
        `MPC_OFF_DUTY2_HIGH: duty_value_ch2_reg[9:8] <= i_wdata[1:0];
        `MPC_OFF_PERIOD_LOW: period_value_reg[7:0] <= i_wdata;
        `MPC_OFF_PERIOD_HIGH: period_value_reg[9:8] <= i_wdata[1:0];
        `MPC_OFF_IRQ_MASK: irq_mask_reg <= i_wdata[2:0];
        default: irq_mask_reg <= irq_mask_reg;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////
// counter

// underflow: counter back at zero at the end of a pwm cycle
assign underflow = tick && (centre ? (down_reg && count_reg <= 10'h001)
                                   : (count_reg >= act_period_reg));
assign load_now = underflow && reload_request;

always @* begin
  count_next = count_reg;
  down_next = down_reg;
  if (!centre) begin
    down_next = 1'b0;
    if (count_reg >= act_period_reg) begin
      count_next = 10'h000;
    end else begin
      count_next = count_reg + 10'h001;
    end
  end else if (!down_reg) begin
    if (count_reg >= act_period_reg) begin
      down_next = 1'b1;
      count_next = (count_reg == 10'h000) ? 10'h000 : count_reg - 10'h001;
    end else begin
      count_next = count_reg + 10'h001;
    end
  end else begin
    if (count_reg <= 10'h001) begin
      count_next = 10'h000;
      down_next = 1'b0;
    end else begin
      count_next = count_reg - 10'h001;
    end
  end
end

always @(posedge i_mclk) begin
  if (i_reset) begin
    count_reg <= `MPC_RST_WORD;
    down_reg <= 1'b0;
    act_period_reg <= `MPC_RST_WORD;
    act_duty0_reg <= `MPC_RST_WORD;
    act_duty1_reg <= `MPC_RST_WORD;
    act_duty2_reg <= `MPC_RST_WORD;
    reload_clr_reg <= 1'b0;
  end else begin
    reload_clr_reg <= load_now;
    if (!counter_run) begin
      count_reg <= `MPC_RST_WORD;
      down_reg <= 1'b0;
    end else if (tick) begin
      count_reg <= count_next;
      down_reg <= down_next;
    end
    if (load_now) begin
      act_period_reg <= period_value_reg;
      act_duty0_reg <= duty_value_ch0_reg;
      act_duty1_reg <= duty_value_ch1_reg;
      act_duty2_reg <= duty_value_ch2_reg;
    end
  end
end

////////////////////////////////////////////////////////////////
// outputs and interrupt

// duty match on a counter step in centre mode
assign duty_hit = tick && centre && (count_next == act_duty0_reg);
assign irq_set[`MPC_IRQ_UNDERFLOW] = underflow;
assign irq_set[`MPC_IRQ_DUTY_UP] = duty_hit && !down_next && centre_duty_irq_sel[0];
assign irq_set[`MPC_IRQ_DUTY_DOWN] = duty_hit && down_next && centre_duty_irq_sel[1];

always @(posedge i_mclk) begin
  if (i_reset) begin
    o_modulated_output <= 3'h0;
    irq_status_reg <= 3'h0;
    o_irq <= 1'b0;
  end else begin
    if (!counter_run) begin
      o_modulated_output <= 3'h0;
    end else begin
      o_modulated_output[0] <= (count_reg < act_duty0_reg);
      o_modulated_output[1] <= (count_reg < act_duty1_reg);
      o_modulated_output[2] <= (count_reg < act_duty2_reg);
    end
    // set wins over the read clear
    irq_status_reg <= (rd_status ? 3'h0 : irq_status_reg) | irq_set;
    o_irq <= |(((rd_status ? 3'h0 : irq_status_reg) | irq_set) & irq_mask_reg);
  end
end

////////////////////////////////////////////////////////////////
// register reads

always @(posedge i_mclk) begin
  if (i_reset) begin
    o_rdata <= `MPC_RST_BYTE;
  end else if (i_rd) begin
    case (i_addr)
      `MPC_OFF_CONTROL: o_rdata <= control_reg;
      `MPC_OFF_DUTY0_LOW: o_rdata <= duty_value_ch0_reg[7:0];
      `MPC_OFF_DUTY0_HIGH: o_rdata <= {6'h00, duty_value_ch0_reg[9:8]};
      `MPC_OFF_DUTY1_LOW: o_rdata <= duty_value_ch1_reg[7:0];
      `MPC_OFF_DUTY1_HIGH: o_rdata <= {6'h00, duty_value_ch1_reg[9:8]};
      `MPC_OFF_DUTY2_LOW: o_rdata <= duty_value_ch2_reg[7:0];
      `MPC_OFF_DUTY2_HIGH: o_rdata <= {6'h00, duty_value_ch2_reg[9:8]};
      `MPC_OFF_PERIOD_LOW: o_rdata <= period_value_reg[7:0];
      `MPC_OFF_PERIOD_HIGH: o_rdata <= {6'h00, period_value_reg[9:8]};
      `MPC_OFF_COUNT_LOW: o_rdata <= count_reg[7:0];
      `MPC_OFF_COUNT_HIGH: o_rdata <= {6'h00, count_reg[9:8]};
      `MPC_OFF_IRQ_STATUS: o_rdata <= {5'h00, irq_status_reg};
      `MPC_OFF_IRQ_MASK: o_rdata <= {5'h00, irq_mask_reg};
      default: o_rdata <= 8'h00;
    endcase
  end else begin
    o_rdata <= 8'h00;
  end
end

endmodule

// [test/mpc_gate_model.sv]
// gate driver stand-in: records which pwm lines went high
// sits on the modulated outputs; clear is synchronous
`timescale 1ns/100ps
module mpc_gate_model (
  input wire i_mclk, // clock
  input wire i_clr, // clear flags
  input wire [2:0] i_pwm, // pwm lines
  output reg [2:0] o_seen // sticky high flags
);
  initial o_seen = 3'h0;
  always @(posedge i_mclk) begin
    if (i_clr)
      o_seen <= 3'h0;
    else
      o_seen <= o_seen | i_pwm;
  end
endmodule

// [test/mpc_pwm_counter_properties.sv]
// port checker for the pwm counter
// bound to mpc_pwm_counter; one clock domain
`timescale 1ns/100ps
module mpc_checker (
  input wire i_mclk, // clock
  input wire i_reset, // reset
  input wire [3:0] i_addr, // offset
  input wire [7:0] i_wdata, // write data
  input wire i_wr, // write strobe
  input wire i_rd, // read strobe
  input wire [7:0] o_rdata, // read data
  input wire [2:0] o_modulated_output, // pwm
  input wire o_irq // interrupt
);
  reg run_q;
  reg [2:0] msk_q;
  reg [2:0] off_n;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  always @(posedge i_mclk) begin
    if (i_reset) begin
      run_q <= 1'b0;
      msk_q <= 3'h0;
      off_n <= 3'h7;
    end else begin
      if (i_wr && i_addr == 4'h0)
        run_q <= i_wdata[3];
      if (i_wr && i_addr == 4'hc)
        msk_q <= i_wdata[2:0];
      off_n <= run_q ? 3'h0 : (off_n == 3'h7 ? off_n : off_n + 3'h1);
    end
  end
  rdata_idle_a: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
  unmapped_zero_a: assert property (
    $past(i_rd) && $past(i_addr) > 4'hc |-> o_rdata == 8'h00) else $error("unmapped read");
  high_zero_a: assert property (
    $past(i_rd) && $past(i_addr) inside {4'h2, 4'h4, 4'h6, 4'h8, 4'ha}
    |-> o_rdata[7:2] == 6'h00) else $error("high byte upper bits");
  byte_back_a: assert property (
    $past(i_wr, 3) && $past(i_rd) && $past(i_addr) == $past(i_addr, 3)
    && $past(i_addr) inside {4'h1, 4'h3, 4'h5, 4'h7}
    |-> o_rdata == $past(i_wdata, 3)) else $error("low byte readback");
  ctrl_back_a: assert property (
    $past(i_wr, 3) && $past(i_rd) && $past(i_addr) == 4'h0 && $past(i_addr, 3) == 4'h0
    && !$past(i_wdata[0], 3) |-> o_rdata == $past(i_wdata, 3)) else $error("control readback");
  stop_pwm_a: assert property (
    off_n >= 3'h3 |-> o_modulated_output == 3'h0) else $error("pwm while stopped");
  stop_count_a: assert property (
    $past(i_rd) && $past(off_n) >= 3'h3 && $past(i_addr) inside {4'h9, 4'ha}
    |-> o_rdata == 8'h00) else $error("count while stopped");
  irq_masked_a: assert property (
    msk_q == 3'h0 && $past(msk_q) == 3'h0 |-> !o_irq) else $error("irq while masked");
  irq_c: cover property ($rose(o_irq));
  run_c: cover property (run_q && o_modulated_output == 3'h5);
  stop_c: cover property (off_n == 3'h3);
endmodule
bind mpc_pwm_counter mpc_checker u_mpc_checker (.i_mclk(i_mclk), .i_reset(i_reset),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_modulated_output(o_modulated_output), .o_irq(o_irq));

// [test/testbench.sv]
// self-checking bench for the pwm counter
// drives the register port; gate model watches the outputs
`timescale 1ns/100ps
module testbench;
  reg i_mclk = 1'b0;
  reg i_reset = 1'b1;
  reg [3:0] i_addr = 4'h0;
  reg [7:0] i_wdata = 8'h00;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg clr = 1'b0;
  wire [7:0] o_rdata;
  wire [2:0] o_modulated_output;
  wire o_irq;
  wire [2:0] seen;
  integer miscompares = 0;
  integer tests_run = 0;
  integer mdl [0:15];
  integer k, v;
  reg [7:0] d, x;
  reg [3:0] a;
  mpc_pwm_counter u_mpc_pwm_counter (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_modulated_output(o_modulated_output), .o_irq(o_irq));
  mpc_gate_model u_mpc_gate_model (.i_mclk(i_mclk), .i_clr(clr), .i_pwm(o_modulated_output),
    .o_seen(seen));
  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end
  task tk(input integer n);
    repeat (n) @(posedge i_mclk);
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: saw %h, expected %h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task wr(input [3:0] ad, input [7:0] dt);
    begin
      i_addr <= ad;
      i_wdata <= dt;
      i_wr <= 1'b1;
      tk(1);
      i_wr <= 1'b0;
      tk(1);
    end
  endtask
  task rd(input [3:0] ad);
    begin
      i_addr <= ad;
      i_rd <= 1'b1;
      tk(1);
      i_rd <= 1'b0;
      // read data settle after this edge and stand until the next one
      #1 d = o_rdata;
      tk(1);
    end
  endtask
  task wait_irq;
    integer n;
    begin
      for (n = 0; n < 1000 && o_irq !== 1'b1; n = n + 1)
        tk(1);
      chk({7'h00, o_irq}, 8'h01);
      if (o_irq !== 1'b1)
        wrap_up;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    v = $urandom(32'h2d7d);
    tk(3);
    i_reset <= 1'b0;
    tk(1);
    for (k = 0; k < 16; k = k + 1) begin
      mdl[k] = 0;
      rd(k[3:0]);
      chk(d, 8'h00);
    end
    for (k = 0; k < 4; k = k + 1) begin
      a = {k[2:0], 1'b0} + 4'h2;
      x = $urandom;
      mdl[a] = x & 8'h03;
      wr(a, x);
      rd(a);
      chk(d, mdl[a][7:0]);
      a = a - 4'h1;
      x = $urandom;
      mdl[a] = x;
      wr(a, x);
      rd(a);
      chk(d, mdl[a][7:0]);
    end
    wr(4'h9, 8'h5a);
    rd(4'h9);
    chk(d, 8'h00);
    // period 255, duties 3, 0 and 300
    wr(4'h8, 8'h00);
    wr(4'h7, 8'hff);
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h03);
    wr(4'h4, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h6, 8'h01);
    wr(4'h5, 8'h2c);
    wr(4'h0, 8'h08);
    clr <= 1'b1;
    tk(1);
    clr <= 1'b0;
    tk(40);
    chk({5'h00, seen}, 8'h00);
    wr(4'h0, 8'h09);
    tk(600);
    rd(4'h0);
    chk(d, 8'h08);
    chk({5'h00, seen}, 8'h05);
    for (k = 0; k < 4; k = k + 1) begin
      wr(4'h0, 8'h00);
      wr(4'h0, {2'b00, k[1:0], 4'h8});
      rd(4'h0);
      chk(d, {2'b00, k[1:0], 4'h8});
      tk(62);
      rd(4'h9);
      v = d - (64 >> k);
      chk({7'h00, v >= -2 && v <= 2}, 8'h01);
    end
    wr(4'h0, 8'h00);
    rd(4'h0);
    tk(2);
    rd(4'ha);
    chk(d, 8'h00);
    chk({5'h00, o_modulated_output}, 8'h00);
    wr(4'hc, 8'h01);
    wr(4'h0, 8'h08);
    wait_irq;
    rd(4'hb);
    chk(d & 8'h01, 8'h01);
    tk(1);
    chk({7'h00, o_irq}, 8'h00);
    wr(4'hc, 8'h06);
    for (k = 0; k < 4; k = k + 1) begin
      wr(4'h0, {1'b1, k[0], 3'b001, k[1:0], 1'b0});
      rd(4'hb);
      tk(600);
      rd(4'hb);
      chk(d & 8'h06, {5'h00, k[1:0], 1'b0});
    end
    wr(4'hc, 8'h00);
    tk(1);
    chk({7'h00, o_irq}, 8'h00);
    wrap_up;
  end
endmodule
